// *** rtl/ccr_ctrl.v ***
// Program counter, status word and stack pointer with memory map decode.
// Assumes the core sequencer drives one request per cycle while busy is low
// and program memory answers a read one cycle after the read strobe.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "ccr_regs.vh"

module ccr_ctrl #(
   parameter [15:0] ROM_TOP  = `CCR_ROM_TOP,
   parameter [15:0] RAM_BASE = `CCR_RAM_BASE,
   parameter [255:0] SFR_MAP = {256{1'b1}}
) (
   input  wire        clk,
   input  wire        rst,
   // Register port
   input  wire [1:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   // Program memory vector fetch
   output reg  [15:0] pm_addr,
   output reg         pm_rd,
   input  wire [7:0]  pm_rdata,
   // Sequencer requests
   input  wire        pc_adv,
   input  wire [2:0]  pc_len,
   input  wire        br_load,
   input  wire [15:0] br_target,
   input  wire        tcall_req,
   input  wire [4:0]  tcall_idx,
   input  wire        fcall_req,
   input  wire [10:0] fcall_ofs,
   input  wire        brk_req,
   // Interrupt logic
   input  wire        irq_req,
   input  wire        irq_low_prio,
   input  wire [4:0]  irq_idx,
   output wire        irq_ack,
   // Flag updates
   input  wire        alu_we,
   input  wire [7:0]  alu_res,
   input  wire        ac_we,
   input  wire        ac_in,
   input  wire        cy_we,
   input  wire        cy_in,
   input  wire        isp_we,
   input  wire        isp_in,
   input  wire        ei_op,
   input  wire        di_op,
   input  wire        bank_sel,
   input  wire [1:0]  bank_num,
   // Stack
   input  wire        psw_push,
   input  wire        psw_pop,
   input  wire [7:0]  psw_pop_data,
   input  wire        sp_push,
   input  wire        sp_pop,
   output reg         stk_wr,
   output reg  [15:0] stk_addr,
   output reg  [7:0]  stk_wdata,
   // Decode
   input  wire [2:0]  rp_idx,
   output wire [15:0] rp_addr,
   input  wire [15:0] dm_addr,
   input  wire        dm_wr,
   output wire        dm_ram,
   output wire        dm_sfr,
   output wire        dm_sfr_wr,
   output wire        fetch_err,
   output wire        busy,
   output wire [15:0] pc,
   output wire [7:0]  processor_state_word,
   output wire [15:0] sp
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_VLO  = 3'h1;
   localparam [2:0] ST_VHI  = 3'h2;
   localparam [2:0] ST_RST  = 3'h3;
   localparam [2:0] ST_VEND = 3'h4;

   reg  [2:0]  state_ff;
   reg  [2:0]  nxt_state;
   reg  [15:0] pc_ff;
   reg  [15:0] nxt_pc;
   reg  [7:0]  psw_ff;
   reg  [7:0]  nxt_psw;
   reg  [15:0] sp_ff;
   reg  [15:0] nxt_sp;
   reg  [7:0]  vlo_ff;
   reg  [7:0]  nxt_vlo;
   reg  [15:0] nxt_pm_addr;
   reg         nxt_pm_rd;
   reg         nxt_stk_wr;
   reg  [15:0] nxt_stk_addr;
   reg  [7:0]  nxt_stk_wdata;
   reg  [15:0] nxt_rdata;
   wire        idle;
   wire        irq_ok;
   wire        vec_take;
   wire        rom_fetch;
   wire        bank_fetch;

   // ----------------------------------------
   // Address functions
   // ----------------------------------------
   function [15:0] vec_addr;
      input [4:0] idx;
      begin
         vec_addr = `CCR_VEC_FIRST + {10'h000, idx, 1'b0};
      end
   endfunction

   function in_range;
      input [15:0] a;
      input [15:0] lo;
      input [15:0] hi;
      begin
         in_range = (a >= lo) && (a <= hi);
      end
   endfunction

   // Stack moves one byte per access in either direction
   function [15:0] sp_step;
      input [15:0] a;
      input        up;
      begin
         sp_step = up ? a + 16'h0001 : a - 16'h0001;
      end
   endfunction

   // ----------------------------------------
   // Map decode
   // ----------------------------------------
   // Pairs are even/odd neighbours inside the selected bank
   assign rp_addr = `CCR_BANK_BASE
                  + {11'h000, psw_ff[`CCR_PSW_BS1], psw_ff[`CCR_PSW_BS0],
                     rp_idx[2:1], 1'b0};

   assign dm_ram = in_range(dm_addr, RAM_BASE, `CCR_RAM_TOP);

   // Unassigned slots are masked out so stray writes never land
   assign dm_sfr = (dm_addr >= `CCR_SFR_BASE)
                 && SFR_MAP[dm_addr[7:0]];

   assign dm_sfr_wr = dm_sfr && dm_wr;

   // Fetches outside ROM, or from the bank area, are flagged
   assign rom_fetch = in_range(pc_ff, `CCR_VEC_RESET, ROM_TOP);
   assign bank_fetch = in_range(pc_ff, `CCR_BANK_BASE, `CCR_RAM_TOP);
   assign fetch_err = !rom_fetch || bank_fetch;

   // ----------------------------------------
   // Interrupt gate
   // ----------------------------------------
   assign idle = (state_ff == ST_IDLE);
   assign irq_ok = irq_req && psw_ff[`CCR_PSW_IE]
                 && (!irq_low_prio || psw_ff[`CCR_PSW_ISP]);
   assign irq_ack = idle && irq_ok;
   assign vec_take = irq_ok || brk_req;
   assign busy = !idle;
   assign pc = pc_ff;
   assign processor_state_word = psw_ff;
   assign sp = sp_ff;

   // ----------------------------------------
   // Sequencing and state update
   // ----------------------------------------
   always @*
   begin
      nxt_state = state_ff;
      nxt_pc = pc_ff;
      nxt_psw = psw_ff;
      nxt_sp = sp_ff;
      nxt_vlo = vlo_ff;
      nxt_pm_addr = pm_addr;
      nxt_pm_rd = 1'b0;
      nxt_stk_wr = 1'b0;
      nxt_stk_addr = stk_addr;
      nxt_stk_wdata = stk_wdata;

      case (state_ff)
         ST_RST:
         begin
            nxt_pm_addr = `CCR_VEC_RESET;
            nxt_pm_rd = 1'b1;
            nxt_state = ST_VLO;
         end
         ST_VLO:
         begin
            // Memory answers a cycle late, so ask for the odd byte now
            nxt_pm_addr = pm_addr + 16'h0001;
            nxt_pm_rd = 1'b1;
            nxt_state = ST_VHI;
         end
         ST_VHI:
         begin
            // Even byte is on the bus: low half of the vector
            nxt_vlo = pm_rdata;
            nxt_state = ST_VEND;
         end
         ST_VEND:
         begin
            // Odd byte is on the bus: high half, vector complete
            nxt_pc = {pm_rdata, vlo_ff};
            nxt_state = ST_IDLE;
         end
         ST_IDLE:
         begin
            if (vec_take)
            begin
               // Interrupt wins over a same-cycle break request
               nxt_pm_addr = irq_ok ? vec_addr(irq_idx)
                                    : `CCR_VEC_BREAK;
               nxt_pm_rd = 1'b1;
               nxt_state = ST_VLO;
               nxt_sp = sp_step(sp_ff, 1'b0);
               nxt_stk_wr = 1'b1;
               nxt_stk_addr = sp_step(sp_ff, 1'b0);
               nxt_stk_wdata = psw_ff;
               nxt_psw[`CCR_PSW_IE] = 1'b0;
            end
            else if (tcall_req)
            begin
               nxt_pm_addr = `CCR_TCALL_BASE
                           + {10'h000, tcall_idx, 1'b0};
               nxt_pm_rd = 1'b1;
               nxt_state = ST_VLO;
            end
            else if (fcall_req)
            begin
               nxt_pc = `CCR_FCALL_BASE | {5'h00, fcall_ofs};
            end
            else if (br_load)
            begin
               nxt_pc = br_target;
            end
            else if (pc_adv)
            begin
               nxt_pc = pc_ff + {13'h0000, pc_len};
            end

            if (!vec_take)
            begin
               if (psw_pop)
               begin
                  nxt_psw = psw_pop_data;
                  nxt_sp = sp_step(sp_ff, 1'b1);
               end
               else
               begin
                  if (alu_we)
                  begin
                     nxt_psw[`CCR_PSW_Z] = (alu_res == 8'h00);
                  end
                  if (ac_we)
                  begin
                     nxt_psw[`CCR_PSW_AC] = ac_in;
                  end
                  if (cy_we)
                  begin
                     nxt_psw[`CCR_PSW_CY] = cy_in;
                  end
                  if (isp_we)
                  begin
                     nxt_psw[`CCR_PSW_ISP] = isp_in;
                  end
                  if (bank_sel)
                  begin
                     nxt_psw[`CCR_PSW_BS1] = bank_num[1];
                     nxt_psw[`CCR_PSW_BS0] = bank_num[0];
                  end
                  if (di_op)
                  begin
                     nxt_psw[`CCR_PSW_IE] = 1'b0;
                  end
                  else if (ei_op)
                  begin
                     nxt_psw[`CCR_PSW_IE] = 1'b1;
                  end
               end

               if (psw_push)
               begin
                  nxt_sp = sp_step(sp_ff, 1'b0);
                  nxt_stk_wr = 1'b1;
                  nxt_stk_addr = sp_step(sp_ff, 1'b0);
                  nxt_stk_wdata = psw_ff;
               end
               else if (sp_push)
               begin
                  nxt_sp = sp_step(sp_ff, 1'b0);
               end
               else if (sp_pop && !psw_pop)
               begin
                  nxt_sp = sp_step(sp_ff, 1'b1);
               end
            end
         end
         default:
         begin
            nxt_state = ST_RST;
         end
      endcase

      // Status word and stack pointer writes land last so a debugger always wins
      if (reg_wr && reg_addr == `CCR_OFS_PSW)
      begin
         nxt_psw = reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == `CCR_OFS_SP)
      begin
         nxt_sp = reg_wdata;
      end
   end

   // ----------------------------------------
   // Register port read
   // ----------------------------------------
   always @*
   begin
      case (reg_addr)
         `CCR_OFS_PC:  nxt_rdata = pc_ff;
         `CCR_OFS_PSW: nxt_rdata = {8'h00, psw_ff};
         `CCR_OFS_SP:  nxt_rdata = sp_ff;
         default:      nxt_rdata = 16'h0000;
      endcase
   end

   // ----------------------------------------
   // Flops
   // ----------------------------------------
   // Stack pointer has no defined power-up value; zero keeps it tidy
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_ff <= ST_RST;
         pc_ff <= `CCR_VEC_RESET;
         psw_ff <= `CCR_PSW_RST;
         sp_ff <= `CCR_SP_RST;
         vlo_ff <= 8'h00;
         pm_addr <= 16'h0000;
         pm_rd <= 1'b0;
         stk_wr <= 1'b0;
         stk_addr <= 16'h0000;
         stk_wdata <= 8'h00;
         reg_rdata <= 16'h0000;
      end
      else
      begin
         state_ff <= nxt_state;
         pc_ff <= nxt_pc;
         psw_ff <= nxt_psw;
         sp_ff <= nxt_sp;
         vlo_ff <= nxt_vlo;
         pm_addr <= nxt_pm_addr;
         pm_rd <= nxt_pm_rd;
         stk_wr <= nxt_stk_wr;
         stk_addr <= nxt_stk_addr;
         stk_wdata <= nxt_stk_wdata;
         if (reg_rd)
         begin
            reg_rdata <= nxt_rdata;
         end
      end
   end

endmodule // ccr_ctrl

// *** rtl/ccr_regs.vh ***
// Constants for the processor control state and fixed memory map.
// Assumes an 8-bit core with a 64 KB address space around this block.
//
// Behaviour
// - Vector table occupies 0000H to 003FH
// - Vectors read low byte even, high odd
// - Resets use 0000H, sources 0004H up, break 003EH
// - Table-call entries live in 0040H to 007FH
// - Fixed-area calls target 0800H to 0FFFH only
// - ROM from 0000H, top set by variant
// - RAM ends FEFFH, starts FD00H or FB00H
// - FEE0H to FEFFH holds four register banks
// - Peripheral registers decoded in FF00H to FFFFH
// - Counter advances by length, loads on branch
// - Reset loads counter from 0000H and 0001H
// - Status word resets to 02H
// - Status word pushed on interrupt, restored on returns
// - Enable flag clear refuses all maskable requests
// - Enable flag cleared by disable or acknowledge
// - Zero flag follows zero result
// - Bank field records last selected bank
// - Half carry follows bit 3 carry or borrow
// - Low-priority requests need priority flag set
// - Carry flag holds overflow, shift-out, bit accumulator
// - Stack pointer predecrements on write, postincrements read
// - Adjacent bank registers pair as 16 bits
`ifndef CCR_REGS_VH
`define CCR_REGS_VH

// ----------------------------------------
// Memory map
// ----------------------------------------
`define CCR_VEC_RESET   16'h0000
`define CCR_VEC_FIRST   16'h0004
`define CCR_VEC_BREAK   16'h003E
`define CCR_VEC_TOP     16'h003F
`define CCR_TCALL_BASE  16'h0040
`define CCR_FCALL_BASE  16'h0800
`define CCR_ROM_TOP     16'h7FFF
`define CCR_RAM_BASE    16'hFB00
`define CCR_RAM_TOP     16'hFEFF
`define CCR_BANK_BASE   16'hFEE0
`define CCR_SFR_BASE    16'hFF00

// ----------------------------------------
// Status word layout and reset
// ----------------------------------------
`define CCR_PSW_IE      7
`define CCR_PSW_Z       6
`define CCR_PSW_BS1     5
`define CCR_PSW_AC      4
`define CCR_PSW_BS0     3
`define CCR_PSW_ISP     1
`define CCR_PSW_CY      0
`define CCR_PSW_RST     8'h02
`define CCR_SP_RST      16'h0000

// ----------------------------------------
// Register port offsets
// ----------------------------------------
`define CCR_OFS_PC      2'h0
`define CCR_OFS_PSW     2'h1
`define CCR_OFS_SP      2'h2

`endif

// *** test/ccr_ctrl_asserts.sv ***
// Checker for the control state block: reset fetch, interrupt entry, flags.
// Bound to the control block; sees only its ports.
`timescale 1ns/100ps

module ccr_ctrl_asserts (
   input wire        clk,
   input wire        rst,
   input wire [15:0] pm_addr,
   input wire        pm_rd,
   input wire        irq_low_prio,
   input wire [4:0]  irq_idx,
   input wire        irq_ack,
   input wire        alu_we,
   input wire [7:0]  alu_res,
   input wire        bank_sel,
   input wire [1:0]  bank_num,
   input wire        fcall_req,
   input wire [10:0] fcall_ofs,
   input wire        brk_req,
   input wire        tcall_req,
   input wire        psw_pop,
   input wire        reg_wr,
   input wire        stk_wr,
   input wire [15:0] stk_addr,
   input wire [15:0] pc,
   input wire [7:0]  processor_state_word,
   input wire [15:0] sp,
   input wire        busy
);
   // Flag loads are only judged when nothing of higher priority competes
   wire quiet = !busy && !irq_ack && !brk_req && !psw_pop && !reg_wr;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   reset_fetch_a: assert property ($fell(rst) |=> pm_rd && pm_addr == 16'h0000
      ##1 pm_rd && pm_addr == 16'h0001) else $error("reset vector fetch wrong");
   reset_psw_a: assert property ($fell(rst) |-> processor_state_word == 8'h02)
      else $error("status word reset wrong");
   ack_gate_a: assert property (irq_ack |-> processor_state_word[7] && (!irq_low_prio || processor_state_word[1]))
      else $error("request taken while gated");
   ack_entry_a: assert property (irq_ack |=> !processor_state_word[7] && stk_wr
      && stk_addr == $past(sp) - 16'h0001) else $error("interrupt entry push wrong");
   irq_vector_a: assert property (irq_ack |=> pm_rd
      && pm_addr == 16'h0004 + {$past(irq_idx), 1'b0} ##1 pm_rd && pm_addr[0])
      else $error("interrupt vector fetch wrong");
   zero_flag_a: assert property (alu_we && quiet |=> processor_state_word[6] == ($past(alu_res) == 8'h00))
      else $error("zero flag wrong");
   bank_field_a: assert property (bank_sel && quiet |=> {processor_state_word[5], processor_state_word[3]} == $past(bank_num))
      else $error("bank field wrong");
   fixed_call_a: assert property (fcall_req && quiet && !tcall_req
      |=> pc == {5'h01, $past(fcall_ofs)}) else $error("fixed call target wrong");

   cover property (irq_ack);
   cover property (fcall_req && quiet);
   cover property ($fell(rst));
endmodule // ccr_ctrl_asserts

bind ccr_ctrl ccr_ctrl_asserts u_chk (.*);

// *** test/ccr_pmem_model.sv ***
// Program memory model answering vector reads one cycle after the strobe.
// Byte at each address is its low address byte plus 11H.
`timescale 1ns/100ps

module ccr_pmem_model (
   input  wire        clk,
   input  wire        pm_rd,
   input  wire [15:0] pm_addr,
   output logic [7:0] pm_rdata = 8'hA5
);
   always @(posedge clk)
      if (pm_rd)
         pm_rdata <= pm_addr[7:0] + 8'h11;
      else
         pm_rdata <= ~pm_rdata; // Idle bus must not look like a stale byte
endmodule // ccr_pmem_model

// *** test/tb.sv ***
// Bench for the control state block: register port, vectors, flags, decode.
// Assumes the program memory model beside it.
`timescale 1ns/100ps

module tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [1:0]  reg_addr, bank_num;
   logic [2:0]  pc_len, rp_idx;
   logic [4:0]  tcall_idx, irq_idx;
   logic [7:0]  alu_res, psw_pop_data;
   logic [10:0] fcall_ofs;
   logic [15:0] reg_wdata, br_target, dm_addr;
   logic        reg_wr, reg_rd, pc_adv, br_load, tcall_req, fcall_req, brk_req, irq_req;
   logic        irq_low_prio, alu_we, ac_we, ac_in, cy_we, cy_in, isp_we, isp_in, ei_op;
   logic        di_op, bank_sel, psw_push, psw_pop, sp_push, sp_pop, dm_wr;
   wire  [15:0] reg_rdata, pm_addr, stk_addr, rp_addr, pc, sp;
   wire  [7:0]  pm_rdata, stk_wdata, processor_state_word;
   wire         pm_rd, irq_ack, stk_wr, dm_ram, dm_sfr, dm_sfr_wr, fetch_err, busy;
   int          fails = 0;
   int          n_checks = 0;

   always #2.5 clk = ~clk;

   // Slot FF00H left unassigned so the SFR mask is exercised
   ccr_ctrl #(.SFR_MAP({{255{1'b1}}, 1'b0})) u_dut (.*);
   ccr_pmem_model u_pmem (.*);

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      if (fails == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Drops every strobe except sp_push, sp_pop and dm_wr after one cycle, then lets the edge settle
   task automatic go();
      @(posedge clk);
      {pc_adv, br_load, tcall_req, fcall_req, brk_req, irq_req, irq_low_prio, alu_we, ac_we,
       cy_we, isp_we, ei_op, di_op, bank_sel, psw_push, psw_pop, reg_wr, reg_rd} <= '0;
      #1;
   endtask

   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      go();
   endtask

   task automatic rd(input logic [1:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      go();
      chk("read", exp, reg_rdata);
   endtask

   task automatic idle();
      int i;
      for (i = 0; i < 9 && busy !== 1'b0; i++)
         @(posedge clk) #1;
      if (i == 9)
      begin
         fails++;
         tally_and_finish();
      end
   endtask

   task automatic dec(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk);
      dm_addr <= a;
      #1 chk("decode", exp, {13'h0000, dm_sfr_wr, dm_ram, dm_sfr});
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      {reg_addr, bank_num, pc_len, rp_idx, tcall_idx, irq_idx, alu_res, psw_pop_data, fcall_ofs,
       reg_wdata, br_target, dm_addr, reg_wr, reg_rd, pc_adv, br_load, tcall_req, fcall_req,
       brk_req, irq_req, irq_low_prio, alu_we, ac_we, ac_in, cy_we, cy_in, isp_we, isp_in,
       ei_op, di_op, bank_sel, psw_push, psw_pop, sp_push, sp_pop, dm_wr} = '0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      idle();
      chk("reset pc", 16'h1211, pc);
      rd(2'h1, 16'h0002);
      rd(2'h3, 16'h0000);
      wr(2'h0, 16'h4321);
      rd(2'h0, 16'h1211);
      wr(2'h2, 16'hFEE0);
      wr(2'h1, 16'h0080);
      @(posedge clk);
      irq_req <= 1'b1;
      irq_low_prio <= 1'b1;
      irq_idx <= 5'h03;
      #1 chk("low ack", 16'h0000, {15'h0000, irq_ack});
      go();
      wr(2'h1, 16'h0082);
      @(posedge clk);
      irq_req <= 1'b1;
      irq_low_prio <= 1'b1;
      #1 chk("ack", 16'h0001, {15'h0000, irq_ack});
      go();
      chk("push addr", 16'hFEDF, stk_addr);
      chk("push data", 16'h0182, {7'h00, stk_wr, stk_wdata});
      chk("ie", 16'h0002, {8'h00, processor_state_word});
      idle();
      chk("irq pc", 16'h1C1B, pc);
      @(posedge clk);
      irq_req <= 1'b1;
      #1 chk("masked", 16'h0000, {15'h0000, irq_ack});
      go();
      wr(2'h1, 16'h0080);
      @(posedge clk);
      brk_req <= 1'b1;
      go();
      idle();
      chk("brk pc", 16'h504F, pc);
      @(posedge clk);
      tcall_req <= 1'b1;
      tcall_idx <= 5'h1F;
      go();
      idle();
      chk("tcall pc", 16'h908F, pc);
      @(posedge clk);
      fcall_req <= 1'b1;
      fcall_ofs <= 11'h7FF;
      go();
      chk("fcall pc", 16'h0FFF, pc);
      @(posedge clk);
      br_load <= 1'b1;
      br_target <= 16'h0100;
      go();
      @(posedge clk);
      pc_adv <= 1'b1;
      pc_len <= 3'h3;
      go();
      chk("adv pc", 16'h0103, pc);
      @(posedge clk);
      br_load <= 1'b1;
      br_target <= 16'hFEE0;
      go();
      chk("bank fetch", 16'h0001, {15'h0000, fetch_err});
      @(posedge clk);
      {alu_we, ac_we, ac_in, cy_we, cy_in, isp_we, ei_op, bank_sel} <= 8'hFF;
      bank_num <= 2'h3;
      rp_idx <= 3'h7;
      go();
      rd(2'h1, 16'h00F9);
      chk("pair", 16'hFEFE, rp_addr);
      @(posedge clk);
      {alu_we, ac_we, ac_in, cy_we, cy_in, isp_we, isp_in, di_op, bank_sel} <= 9'h1AF;
      alu_res <= 8'h10;
      bank_num <= 2'h2;
      go();
      rd(2'h1, 16'h0022);
      wr(2'h2, 16'hFEE0);
      @(posedge clk);
      psw_push <= 1'b1;
      go();
      chk("push sp", 16'hFEDF, sp);
      @(posedge clk);
      psw_pop <= 1'b1;
      psw_pop_data <= 8'h55;
      go();
      chk("pop", 16'h55E0, {processor_state_word, sp[7:0]});
      dec(16'hFAFF, 16'h0000);
      dec(16'hFB00, 16'h0002);
      dec(16'hFF10, 16'h0001);
      dec(16'hFF00, 16'h0000);
      @(posedge clk);
      dm_wr <= 1'b1;
      dec(16'hFF10, 16'h0005);
      dec(16'hFF00, 16'h0000);
      tally_and_finish();
   end
endmodule // tb
